// >>> verilog/ptc_pkg.sv
// package for the phy tuning configuration register bank
// assumes a plain register port with 8-bit register indices
package ptc_pkg;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TX_FINE_GAIN_AB = 8'ha0;
  localparam logic [7:0] ADDR_TX_FINE_GAIN_CD = 8'ha1;
  localparam logic [7:0] ADDR_LINE_SWING_AB = 8'ha2;
  localparam logic [7:0] ADDR_LINE_SWING_CD = 8'ha3;
  localparam logic [7:0] ADDR_RX_LOWPASS = 8'hb3;
  localparam logic [7:0] ADDR_RX_EQ_ENABLE = 8'hc0;
  localparam logic [7:0] ADDR_CLOCK_OUT_SEL = 8'hc6;
  localparam logic [7:0] ADDR_SERIAL_WIRING = 8'hd3;
  localparam logic [7:0] ADDR_ELASTIC_BUF = 8'he9;
  localparam logic [7:0] ADDR_LOOPBACK = 8'hfe;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GAIN_LO_LSB = 0;
  localparam int GAIN_HI_LSB = 8;
  localparam int GAIN_W = 4;
  localparam int SWING_LO_LSB = 0;
  localparam int SWING_HI_LSB = 8;
  localparam int SWING_W = 5;
  localparam int SWING_EN_LO_BIT = 5;
  localparam int SWING_EN_HI_BIT = 13;
  localparam int TEST_CLOCK_SEL_BIT = 4;
  localparam int SIX_WIRE_BIT = 14;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] SWING_RESET = 5'h10;
  localparam logic [15:0] ELASTIC_BUF_RESET = 16'h9f22;
  localparam logic [15:0] LOOPBACK_RESET = 16'h0001;
  localparam logic [15:0] RX_LOWPASS_RESET = 16'h0000;
  localparam logic [15:0] RX_EQ_ENABLE_RESET = 16'h0000;
  localparam logic [3:0] GAIN_MID_CODE = 4'h8;
  // gain in units of two percent relative to nominal
  localparam logic signed [3:0] GAIN_STEP_PCT = 4'sh2;
endpackage

// >>> verilog/ptc_trim_field.sv
// one trimmed gain field: loads its calibration code at reset
// assumes trim_code is static while rst is high
`timescale 1ns/1ps
module ptc_trim_field (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // calibration and write path
  input wire logic [3:0] trim_code,
  input wire logic wr_en,
  input wire logic [3:0] wr_data,
  // field value and decoded gain step
  output logic [3:0] value,
  output logic signed [4:0] gain_steps
);
  logic [3:0] value_reg;
  logic [3:0] value_next;

  // RULE_13 trim load at reset
  always_comb begin
    value_next = value_reg;
    if (rst) begin
      value_next = trim_code;
    end else if (wr_en) begin
      value_next = wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    value_reg <= value_next;
  end

  assign value = value_reg;

  // RULE_01 code to gain
  // steps of two percent; code 0 is -8 steps, code 15 is +7 steps
  always_comb begin
    gain_steps = $signed({1'b0, value_reg}) -
      $signed({1'b0, ptc_pkg::GAIN_MID_CODE});
  end
endmodule

// >>> verilog/ptc_swing_field.sv
// one line driver swing field with its override enable
// assumes internal_swing comes from the analog calibration path
`timescale 1ns/1ps
module ptc_swing_field (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // write path
  input wire logic wr_en,
  input wire logic wr_override_en,
  input wire logic [4:0] wr_swing,
  // internal swing when not overridden
  input wire logic [4:0] internal_swing,
  // stored fields and effective swing
  output logic override_en,
  output logic [4:0] swing_value,
  output logic [4:0] swing_eff
);
  logic en_reg;
  logic en_next;
  logic [4:0] val_reg;
  logic [4:0] val_next;

  always_comb begin
    en_next = en_reg;
    val_next = val_reg;
    if (rst) begin
      en_next = 1'b0;
      val_next = ptc_pkg::SWING_RESET;
    end else if (wr_en) begin
      en_next = wr_override_en;
      val_next = wr_swing;
    end
  end

  always_ff @(posedge clk_sys) begin
    en_reg <= en_next;
    val_reg <= val_next;
  end

  assign override_en = en_reg;
  assign swing_value = val_reg;
  // RULE_04 override selects tune
  assign swing_eff = en_reg ? val_reg : internal_swing;
endmodule

// >>> verilog/ptc_regs.sv
// phy tuning configuration register bank, top level
// assumes a same-clock register port; read data one cycle after strobe
// Functional notes
// RULE_01: gain code 0 is -16%, code 8 no change, code 15 +14%, 2% steps
// RULE_02: first gain register holds channel a in 3:0, channel b in 11:8
// RULE_03: second gain register holds channels c and d the same way
// RULE_04: channel a swing override enable selects five-bit tune field
// RULE_05: channels b, c, d have own override bit and swing field
// RULE_06: clock mux bit routes internal transmit test clock to clock out
// RULE_07: serial type bit selects six-wire mode with clock to mac
// RULE_08: reserved bits in clock-out and serial registers read zero
// RULE_09: software soft-resets after changing the loopback word
// RULE_10: software programs only the documented loopback pattern
// RULE_11: software may set lowpass word for emc immunity
// RULE_12: software may clear equalizer enable word for emc immunity
// RULE_13: trimmed fields load calibration at reset, stay writable
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module ptc_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // calibration inputs, static during reset
  input wire logic [3:0] trim_gain_a,
  input wire logic [3:0] trim_gain_b,
  input wire logic [3:0] trim_gain_c,
  input wire logic [3:0] trim_gain_d,
  input wire logic [4:0] internal_swing_a,
  input wire logic [4:0] internal_swing_b,
  input wire logic [4:0] internal_swing_c,
  input wire logic [4:0] internal_swing_d,
  // analog controls
  output logic [3:0] tx_gain_trim_ch_a,
  output logic [3:0] tx_gain_trim_ch_b,
  output logic [3:0] tx_gain_trim_ch_c,
  output logic [3:0] tx_gain_trim_ch_d,
  output logic signed [4:0] tx_gain_step_a,
  output logic signed [4:0] tx_gain_step_b,
  output logic signed [4:0] tx_gain_step_c,
  output logic signed [4:0] tx_gain_step_d,
  output logic [4:0] line_swing_a,
  output logic [4:0] line_swing_b,
  output logic [4:0] line_swing_c,
  output logic [4:0] line_swing_d,
  output logic [15:0] rx_lowpass_word,
  output logic [15:0] rx_equalizer_enable_word,
  output logic test_clock_select,
  output logic six_wire_mode,
  output logic [15:0] elastic_buffer_word,
  output logic [15:0] loopback_word
);
  // ----------------------------------------------------------------
  // per-channel fields
  // ----------------------------------------------------------------
  logic [3:0] trim_in [4];
  logic [4:0] int_swing [4];
  logic [3:0] gain_val [4];
  logic signed [4:0] gain_step [4];
  logic sw_en [4];
  logic [4:0] sw_val [4];
  logic [4:0] sw_eff [4];
  logic gain_wr [4];
  logic swing_wr [4];
  logic [3:0] gain_wdata [4];
  logic sw_en_wdata [4];
  logic [4:0] sw_wdata [4];

  assign trim_in[0] = trim_gain_a;
  assign trim_in[1] = trim_gain_b;
  assign trim_in[2] = trim_gain_c;
  assign trim_in[3] = trim_gain_d;
  assign int_swing[0] = internal_swing_a;
  assign int_swing[1] = internal_swing_b;
  assign int_swing[2] = internal_swing_c;
  assign int_swing[3] = internal_swing_d;

  // channels 0,2 sit in the low fields, 1,3 in the high fields
  // one word write updates both channels of a pair together;
  // there is no per-field mask, so software rewrites the partner
  // field with its current value when it changes only one channel
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_ch
      localparam bit HI = (ch % 2) == 1;
      localparam logic [7:0] GAIN_ADDR = (ch < 2) ?
        ptc_pkg::ADDR_TX_FINE_GAIN_AB : ptc_pkg::ADDR_TX_FINE_GAIN_CD;
      localparam logic [7:0] SW_ADDR = (ch < 2) ?
        ptc_pkg::ADDR_LINE_SWING_AB : ptc_pkg::ADDR_LINE_SWING_CD;
      localparam int GLSB = HI ? ptc_pkg::GAIN_HI_LSB :
        ptc_pkg::GAIN_LO_LSB;
      localparam int SLSB = HI ? ptc_pkg::SWING_HI_LSB :
        ptc_pkg::SWING_LO_LSB;
      localparam int EBIT = HI ? ptc_pkg::SWING_EN_HI_BIT :
        ptc_pkg::SWING_EN_LO_BIT;

      // RULE_02 gain nibble decode
      // RULE_03 second gain register
      assign gain_wr[ch] = reg_wr && (reg_addr == GAIN_ADDR);
      assign gain_wdata[ch] = reg_wdata[GLSB +: ptc_pkg::GAIN_W];
      // RULE_05 per-channel swing fields
      assign swing_wr[ch] = reg_wr && (reg_addr == SW_ADDR);
      assign sw_en_wdata[ch] = reg_wdata[EBIT];
      assign sw_wdata[ch] = reg_wdata[SLSB +: ptc_pkg::SWING_W];

      ptc_trim_field u_gain (
        .clk_sys(clk_sys),
        .rst(rst),
        .trim_code(trim_in[ch]),
        .wr_en(gain_wr[ch]),
        .wr_data(gain_wdata[ch]),
        .value(gain_val[ch]),
        .gain_steps(gain_step[ch])
      );

      ptc_swing_field u_swing (
        .clk_sys(clk_sys),
        .rst(rst),
        .wr_en(swing_wr[ch]),
        .wr_override_en(sw_en_wdata[ch]),
        .wr_swing(sw_wdata[ch]),
        .internal_swing(int_swing[ch]),
        .override_en(sw_en[ch]),
        .swing_value(sw_val[ch]),
        .swing_eff(sw_eff[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // whole-word and single-bit registers
  // ----------------------------------------------------------------
  logic [15:0] lowpass_reg;
  logic [15:0] lowpass_next;
  logic [15:0] eq_en_reg;
  logic [15:0] eq_en_next;
  logic [15:0] elastic_reg;
  logic [15:0] elastic_next;
  logic [15:0] loop_reg;
  logic [15:0] loop_next;
  logic clk_sel_reg;
  logic clk_sel_next;
  logic six_wire_reg;
  logic six_wire_next;

  // filter and equalizer words have no fixed default; zero chosen
  always_comb begin
    lowpass_next = lowpass_reg;
    eq_en_next = eq_en_reg;
    elastic_next = elastic_reg;
    loop_next = loop_reg;
    clk_sel_next = clk_sel_reg;
    six_wire_next = six_wire_reg;
    if (rst) begin
      lowpass_next = ptc_pkg::RX_LOWPASS_RESET;
      eq_en_next = ptc_pkg::RX_EQ_ENABLE_RESET;
      elastic_next = ptc_pkg::ELASTIC_BUF_RESET;
      loop_next = ptc_pkg::LOOPBACK_RESET;
      clk_sel_next = 1'b0;
      six_wire_next = 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        ptc_pkg::ADDR_RX_LOWPASS: begin
          lowpass_next = reg_wdata;
        end
        ptc_pkg::ADDR_RX_EQ_ENABLE: begin
          eq_en_next = reg_wdata;
        end
        ptc_pkg::ADDR_ELASTIC_BUF: begin
          elastic_next = reg_wdata;
        end
        // new value only trusted after a soft reset elsewhere;
        // limitation: this block cannot see when that reset happens
        ptc_pkg::ADDR_LOOPBACK: begin
          loop_next = reg_wdata;
        end
        // RULE_06 test clock select
        ptc_pkg::ADDR_CLOCK_OUT_SEL: begin
          clk_sel_next = reg_wdata[ptc_pkg::TEST_CLOCK_SEL_BIT];
        end
        // RULE_07 six-wire select
        ptc_pkg::ADDR_SERIAL_WIRING: begin
          six_wire_next = reg_wdata[ptc_pkg::SIX_WIRE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    lowpass_reg <= lowpass_next;
    eq_en_reg <= eq_en_next;
    elastic_reg <= elastic_next;
    loop_reg <= loop_next;
    clk_sel_reg <= clk_sel_next;
    six_wire_reg <= six_wire_next;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [15:0] rd_word;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // RULE_08 reserved bits read zero
  always_comb begin
    rd_word = 16'h0000;
    case (reg_addr)
      ptc_pkg::ADDR_TX_FINE_GAIN_AB: begin
        rd_word[ptc_pkg::GAIN_LO_LSB +: ptc_pkg::GAIN_W] = gain_val[0];
        rd_word[ptc_pkg::GAIN_HI_LSB +: ptc_pkg::GAIN_W] = gain_val[1];
      end
      ptc_pkg::ADDR_TX_FINE_GAIN_CD: begin
        rd_word[ptc_pkg::GAIN_LO_LSB +: ptc_pkg::GAIN_W] = gain_val[2];
        rd_word[ptc_pkg::GAIN_HI_LSB +: ptc_pkg::GAIN_W] = gain_val[3];
      end
      ptc_pkg::ADDR_LINE_SWING_AB: begin
        rd_word[ptc_pkg::SWING_LO_LSB +: ptc_pkg::SWING_W] = sw_val[0];
        rd_word[ptc_pkg::SWING_EN_LO_BIT] = sw_en[0];
        rd_word[ptc_pkg::SWING_HI_LSB +: ptc_pkg::SWING_W] = sw_val[1];
        rd_word[ptc_pkg::SWING_EN_HI_BIT] = sw_en[1];
      end
      ptc_pkg::ADDR_LINE_SWING_CD: begin
        rd_word[ptc_pkg::SWING_LO_LSB +: ptc_pkg::SWING_W] = sw_val[2];
        rd_word[ptc_pkg::SWING_EN_LO_BIT] = sw_en[2];
        rd_word[ptc_pkg::SWING_HI_LSB +: ptc_pkg::SWING_W] = sw_val[3];
        rd_word[ptc_pkg::SWING_EN_HI_BIT] = sw_en[3];
      end
      ptc_pkg::ADDR_RX_LOWPASS: begin
        rd_word = lowpass_reg;
      end
      ptc_pkg::ADDR_RX_EQ_ENABLE: begin
        rd_word = eq_en_reg;
      end
      ptc_pkg::ADDR_CLOCK_OUT_SEL: begin
        rd_word[ptc_pkg::TEST_CLOCK_SEL_BIT] = clk_sel_reg;
      end
      ptc_pkg::ADDR_SERIAL_WIRING: begin
        rd_word[ptc_pkg::SIX_WIRE_BIT] = six_wire_reg;
      end
      ptc_pkg::ADDR_ELASTIC_BUF: begin
        rd_word = elastic_reg;
      end
      ptc_pkg::ADDR_LOOPBACK: begin
        rd_word = loop_reg;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // decode uses the strobe cycle's address, so it need not be held
  // data is held only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = 16'h0000;
    if (!rst && reg_rd) begin
      rdata_next = rd_word;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // outputs are re-registered so every top output leaves a flip-flop;
  // costs one cycle of latency on the gain, gain step and line swing controls
  logic [3:0] gain_o_reg [4];
  logic signed [4:0] step_o_reg [4];
  logic [4:0] swing_o_reg [4];

  always_ff @(posedge clk_sys) begin
    rdata_reg <= rdata_next;
    for (int i = 0; i < 4; i++) begin
      gain_o_reg[i] <= gain_val[i];
      step_o_reg[i] <= gain_step[i];
      swing_o_reg[i] <= sw_eff[i];
    end
  end

  assign reg_rdata = rdata_reg;
  assign tx_gain_trim_ch_a = gain_o_reg[0];
  assign tx_gain_trim_ch_b = gain_o_reg[1];
  assign tx_gain_trim_ch_c = gain_o_reg[2];
  assign tx_gain_trim_ch_d = gain_o_reg[3];
  assign tx_gain_step_a = step_o_reg[0];
  assign tx_gain_step_b = step_o_reg[1];
  assign tx_gain_step_c = step_o_reg[2];
  assign tx_gain_step_d = step_o_reg[3];
  assign line_swing_a = swing_o_reg[0];
  assign line_swing_b = swing_o_reg[1];
  assign line_swing_c = swing_o_reg[2];
  assign line_swing_d = swing_o_reg[3];
  assign rx_lowpass_word = lowpass_reg;
  assign rx_equalizer_enable_word = eq_en_reg;
  assign test_clock_select = clk_sel_reg;
  assign six_wire_mode = six_wire_reg;
  assign elastic_buffer_word = elastic_reg;
  assign loopback_word = loop_reg;
endmodule

// >>> tb/ptc_regs_monitor.sv
// assertions on the phy tuning register bank ports
// assumes one clock domain; bound onto ptc_regs below
`timescale 1ns/1ps
module ptc_regs_monitor (
  // clock, reset and register port
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // calibration and controls watched
  input wire logic [3:0] trim_gain_a,
  input wire logic [4:0] internal_swing_a,
  input wire logic [3:0] tx_gain_trim_ch_a,
  input wire logic [3:0] tx_gain_trim_ch_b,
  input wire logic [3:0] tx_gain_trim_ch_c,
  input wire logic signed [4:0] tx_gain_step_a,
  input wire logic [4:0] line_swing_a,
  input wire logic [4:0] line_swing_d
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // --------------------------------------------------------------
  // delayed copies of write data and internal swing
  // --------------------------------------------------------------
  logic [15:0] wd1_reg;
  logic [15:0] wd2_reg;
  logic [4:0] isa_reg;
  always_ff @(posedge clk_sys) begin
    wd1_reg <= reg_wdata;
    wd2_reg <= wd1_reg;
    isa_reg <= internal_swing_a;
  end
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  AST_STEP_A: assert property (
    $stable(tx_gain_trim_ch_a) && !$past(rst) |->
      tx_gain_step_a == 5'({1'b0, tx_gain_trim_ch_a} - 5'h8))
    else $error("gain step a does not match its code");
  AST_GAIN_B: assert property (
    reg_wr && reg_addr == 8'ha0 |-> ##2 tx_gain_trim_ch_b == wd2_reg[11:8])
    else $error("gain b not taken from bits 11:8");
  AST_GAIN_C: assert property (
    reg_wr && reg_addr == 8'ha1 |-> ##2 tx_gain_trim_ch_c == wd2_reg[3:0])
    else $error("gain c not taken from bits 3:0");
  AST_SWING_A: assert property (
    reg_wr && reg_addr == 8'ha2 && reg_wdata[5] |->
      ##2 line_swing_a == wd2_reg[4:0])
    else $error("swing a not forced from field");
  AST_SWING_INT: assert property (
    reg_wr && reg_addr == 8'ha2 && !reg_wdata[5] |->
      ##2 line_swing_a == isa_reg)
    else $error("swing a not internal when override clear");
  AST_SWING_D: assert property (
    reg_wr && reg_addr == 8'ha3 && reg_wdata[13] |->
      ##2 line_swing_d == wd2_reg[12:8])
    else $error("swing d not forced from field");
  AST_CLK_RSVD: assert property (
    reg_rd && reg_addr == 8'hc6 |=> (reg_rdata & 16'hffef) == 16'h0000)
    else $error("clock out reserved bits not zero");
  AST_SER_RSVD: assert property (
    reg_rd && reg_addr == 8'hd3 |=> (reg_rdata & 16'hbfff) == 16'h0000)
    else $error("serial wiring reserved bits not zero");
  AST_TRIM_LOAD: assert property (
    $fell(rst) |-> tx_gain_trim_ch_a == trim_gain_a)
    else $error("gain a did not load its trim at reset");
endmodule

bind ptc_regs ptc_regs_monitor u_mon (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .trim_gain_a(trim_gain_a),
  .internal_swing_a(internal_swing_a),
  .tx_gain_trim_ch_a(tx_gain_trim_ch_a),
  .tx_gain_trim_ch_b(tx_gain_trim_ch_b),
  .tx_gain_trim_ch_c(tx_gain_trim_ch_c),
  .tx_gain_step_a(tx_gain_step_a),
  .line_swing_a(line_swing_a), .line_swing_d(line_swing_d)
);

// >>> tb/ptc_regs_bench.sv
// self-checking bench for the phy tuning register bank
// assumes ptc_regs with its checker bound in by the monitor file
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  n_fail++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module ptc_regs_bench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, ex_now, lpf_w, eq_w, ebuf_w, loop_w;
  logic [3:0] trim [4];
  logic [4:0] isw [4];
  logic [3:0] gain [4];
  logic signed [4:0] step [4];
  logic [4:0] swing [4];
  logic clk_sel, six_w;
  logic rd_seen = 1'b0;
  logic [15:0] exp_q [$];
  int n_fail = 0;
  int checks_done = 0;
  logic [31:0] rng = 32'h0000005c;
  localparam logic [7:0] RA [9] = '{8'ha2, 8'ha3, 8'hb3, 8'hc0, 8'hc6,
    8'hd3, 8'he9, 8'hfe, 8'h55};
  localparam logic [15:0] RV [9] = '{16'h1010, 16'h1010, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h9f22, 16'h0001, 16'h0000};

  ptc_regs dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .trim_gain_a(trim[0]), .trim_gain_b(trim[1]),
    .trim_gain_c(trim[2]), .trim_gain_d(trim[3]),
    .internal_swing_a(isw[0]), .internal_swing_b(isw[1]),
    .internal_swing_c(isw[2]), .internal_swing_d(isw[3]),
    .tx_gain_trim_ch_a(gain[0]), .tx_gain_trim_ch_b(gain[1]),
    .tx_gain_trim_ch_c(gain[2]), .tx_gain_trim_ch_d(gain[3]),
    .tx_gain_step_a(step[0]), .tx_gain_step_b(step[1]),
    .tx_gain_step_c(step[2]), .tx_gain_step_d(step[3]),
    .line_swing_a(swing[0]), .line_swing_b(swing[1]),
    .line_swing_c(swing[2]), .line_swing_d(swing[3]),
    .rx_lowpass_word(lpf_w), .rx_equalizer_enable_word(eq_w),
    .test_clock_select(clk_sel), .six_wire_mode(six_w),
    .elastic_buffer_word(ebuf_w), .loopback_word(loop_w)
  );

  always #5 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // wr and rd each raise their own strobe and lower the other, leaving their own high, so back-to-back calls are safe; idle lowers both
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] ex);
    exp_q.push_back(ex);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      ex_now = exp_q.pop_front();
      `CHK("read data", ex_now, reg_rdata)
    end
    rd_seen <= reg_rd && !rst;
  end

  // a clean run takes a few hundred cycles; this allows about 20000
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] w;
    logic [3:0] c;
    for (int i = 0; i < 4; i++) begin
      trim[i] <= 4'(rnd());
      isw[i] <= 5'(rnd());
    end
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'ha0, {4'h0, trim[1], 4'h0, trim[0]});
    rd(8'ha1, {4'h0, trim[3], 4'h0, trim[2]});
    for (int i = 0; i < 9; i++) rd(RA[i], RV[i]);
    idle(2);
    `CHK("swing a", isw[0], swing[0])
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      wr(8'ha0, {4'hf, ~c, 4'hf, c});
      wr(8'ha1, {4'hf, c, 4'hf, ~c});
      rd(8'ha0, {4'h0, ~c, 4'h0, c});
      rd(8'ha1, {4'h0, c, 4'h0, ~c});
      idle(3);
      `CHK("gain a", c, gain[0])
      `CHK("step a", 5'({1'b0, c} - 5'h8), step[0])
      `CHK("step b", 5'({1'b0, ~c} - 5'h8), step[1])
      `CHK("step c", 5'({1'b0, ~c} - 5'h8), step[2])
      `CHK("step d", 5'({1'b0, c} - 5'h8), step[3])
      `CHK("gain d", c, gain[3])
    end
    for (int k = 0; k < 8; k++) begin
      for (int j = 0; j < 4; j++) isw[j] <= 5'(rnd());
      for (int r = 0; r < 2; r++) begin
        w = 16'(rnd());
        w[5] = k[0];
        w[13] = !k[0];
        wr(8'ha2 + 8'(r), w);
        rd(8'ha2 + 8'(r), w & 16'h3f3f);
        idle(3);
        `CHK("swing lo", w[5] ? w[4:0] : isw[2*r], swing[2*r])
        `CHK("swing hi", w[13] ? w[12:8] : isw[2*r+1], swing[2*r+1])
      end
    end
    for (int v = 1; v >= 0; v--) begin
      wr(8'hc6, v ? 16'hffff : 16'hffef);
      wr(8'hd3, v ? 16'hffff : 16'hbfff);
      rd(8'hc6, v ? 16'h0010 : 16'h0000);
      rd(8'hd3, v ? 16'h4000 : 16'h0000);
      idle(3);
      `CHK("test clock", 1'(v), clk_sel)
      `CHK("six wire", 1'(v), six_w)
    end
    w = 16'(rnd());
    // equalizer set first so the clear below is visible
    wr(8'hc0, 16'hffff);
    wr(8'hb3, 16'h000c);
    wr(8'hc0, 16'h0000);
    wr(8'hfe, 16'h7390);
    wr(8'he9, w);
    wr(8'h55, 16'hffff);
    rd(8'hb3, 16'h000c);
    rd(8'hfe, 16'h7390);
    rd(8'he9, w);
    rd(8'h55, 16'h0000);
    idle(3);
    `CHK("lowpass", 16'h000c, lpf_w)
    `CHK("equalizer", 16'h0000, eq_w)
    `CHK("loopback", 16'h7390, loop_w)
    `CHK("elastic", w, ebuf_w)
    // second reset with fresh trims must reload the gain fields
    for (int j = 0; j < 4; j++) trim[j] <= 4'(rnd());
    rst <= 1'b1;
    idle(3);
    rst <= 1'b0;
    idle(1);
    rd(8'ha1, {4'h0, trim[3], 4'h0, trim[2]});
    rd(8'hfe, 16'h0001);
    idle(3);
    `CHK("gain c", trim[2], gain[2])
    give_verdict();
  end
endmodule
